//--- core/rtc_alarm_interrupt_core.v
// Clock core: host port, time, alarm and periodic flags,
// banked RAM with sticky lock, power lockout.
// Host strobes on mclk_i; oscillator and power pins async.
// Behaviour
// [R1] Pending flag rises 244 us before update
// [R2] Periodic event half period before update
// [R3] Alarm flag when time equals alarms
// [R4] Alarm byte top bits 11 matches all
// [R5] RAM at 0E-7F, bank one 00-7F
// [R6] Locked 38-3F: writes ignored, reads FF
// [R7] Lock sticky until hardware reset
// [R8] Inputs blocked on battery, then 62 ms
// [R9] No lockout if divider abnormal or invalid
// [R10] Low battery with reset clears 00-0D
// [R11] Oscillator off while time invalid
// [R12] Divider 000/001 stops oscillator, RAM works
// [R13] Interrupt low when enabled flag set
// [R14] New condition in flag read keeps interrupt
// [R15] One pending event per source
// [R16] Rate decode, 1 and 2 alias
// [R17] Divider decode, 11x holds chain reset
// [R18] Pending flag read-only, 0 when frozen
// [R19] Daylight saving jumps April and October
// [R20] Binary or BCD, 24 or 12 hours
// [R21] Mode bit 3 reads 0
// [R22] Reset keeps rate, divider, format bits
// [R23] Host uses index then data port
// [R24] One second per update
// [R25] Freeze keeps visible time stable
// [R26] Flags clear on flag read, reset
// [R27] Oscillator ticks synchronised to core clock
// [R28] Power status as digital inputs
`timescale 1ns/1ps
`include "rtc_core_regs.vh"

module rtc_alarm_interrupt_core #(
   parameter [22:0] LOCKOUT_CYCLES = `LOCKOUT_MS * 1000 * `CLK_MHZ
) (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       nrst_i,
   // Host index/data port
   input  wire [7:0] io_addr_i,
   input  wire       io_wr_i,
   input  wire       io_rd_i,
   input  wire [7:0] io_wdata_i,
   output reg  [7:0] io_rdata_o,
   output reg        io_rvalid_o,
   // Configuration bits from the chip
   input  wire       ram_bank_sel_i,
   input  wire       ram_lock_set_i,
   // Oscillator and power status pins
   input  wire       osc_32k_i,
   input  wire       on_battery_i,
   input  wire       batt_low_i,
   input  wire       master_reset_input_i,
   // Status outputs
   output reg        irq_out_n_o,
   output reg        osc_enable_o,
   output reg        inputs_locked_o
);

   // Synchronisers and edge history
   reg  [3:0]  sy1_ff;
   reg  [3:0]  sy2_ff;
   reg         osc_prev_ff;
   reg         bat_prev_ff;
   // Battery-backed state
   reg  [7:0]  tk_ff [0:9];
   reg  [7:0]  gp_ram_ff [0:255];
   reg  [3:0]  rs_ff;
   reg  [2:0]  dv_ff;
   reg         set_ff;
   reg         dm_ff;
   reg         hr24_ff;
   reg         dse_ff;
   reg         vrt_ff;
   reg         fall_done_ff;
   reg  [14:0] div_ff;
   // Reset state
   reg  [6:0]  idx_ff;
   reg         pie_ff;
   reg         aie_ff;
   reg         uie_ff;
   reg         pf_ff;
   reg         af_ff;
   reg         uf_ff;
   reg         lock_ff;
   reg         alarm_chk_ff;
   reg  [22:0] lk_cnt_ff;
   reg  [7:0]  rd_val;
   integer     i;

   wire osc_s  = sy2_ff[0];
   wire bat_s  = sy2_ff[1];
   wire blow_s = sy2_ff[2];
   wire mr_s   = sy2_ff[3];

   // Port decode, blocked during lockout
   wire host_ok   = ~inputs_locked_o;                                          // [R8]
   wire idx_wr    = io_wr_i && io_addr_i == `IDX_PORT_ADDR && host_ok;         // [R23]
   wire dat_wr    = io_wr_i && io_addr_i == `DATA_PORT_ADDR && host_ok;        // [R23]
   wire dat_rd    = io_rd_i && io_addr_i == `DATA_PORT_ADDR && host_ok;
   wire rd_any    = io_rd_i && (io_addr_i == `IDX_PORT_ADDR || io_addr_i == `DATA_PORT_ADDR);
   wire clk_area  = ~ram_bank_sel_i && idx_ff < `RAM_BANK0_FIRST;             // [R5]
   wire [7:0] ram_addr = {ram_bank_sel_i, idx_ff};                            // [R5]
   wire lock_cell = lock_ff && idx_ff >= `LOCK_FIRST && idx_ff <= `LOCK_LAST; // [R6]
   wire rd_flags  = dat_rd && clk_area && idx_ff == `REG_IRQ_FLAGS;
   wire rd_valid  = dat_rd && clk_area && idx_ff == `REG_VALID;
   wire a_wr      = dat_wr && clk_area && idx_ff == `REG_RATE_DIV;
   wire b_wr      = dat_wr && clk_area && idx_ff == `REG_MODE_EN;
   wire t_wr      = dat_wr && clk_area && idx_ff < `TIME_REG_COUNT;

   // Power return handling
   wire bat_fall  = bat_prev_ff & ~bat_s;
   wire pwr_clear = bat_fall & blow_s & mr_s;                                 // [R10]

   // Oscillator gating and divider chain
   wire osc_tick  = osc_s & ~osc_prev_ff;                                      // [R27]
   wire osc_run   = vrt_ff && dv_ff[2:1] != 2'b00;                            // [R11] [R12] [R17]
   wire div_hold  = dv_ff[2:1] == 2'b11;                                       // [R17]
   wire div_step  = osc_tick && osc_run && ~div_hold;
   wire [14:0] div_nxt = div_ff + 15'h0001;
   wire upd_evt   = div_step && div_ff == `DIV_UPDATE_AT && ~set_ff;           // [R24] [R25]
   wire [31:0] uip_full  = `DIV_UPDATE_AT - `UIP_LEAD_TICKS + 1;
   wire [14:0] uip_start = uip_full[14:0];
   wire uip_now   = osc_run && ~div_hold && div_ff >= uip_start;              // [R1]

   // Periodic tap; codes 1 and 2 alias 8 and 9
   wire [3:0] rs_eff = (rs_ff == 4'h1) ? 4'h8 : (rs_ff == 4'h2) ? 4'h9 : rs_ff; // [R16]
   wire [3:0] per_sh = rs_eff - 4'h1;
   wire [14:0] per_mask = (15'h0001 << per_sh) - 15'h0001;
   wire [14:0] per_half = 15'h0001 << (per_sh - 4'h1);
   wire per_evt = div_step && rs_ff != 4'h0 && (div_nxt & per_mask) == per_half; // [R2] [R16]

   // Field steppers
   wire       bcd = ~dm_ff;                                                   // [R20]
   wire [7:0] sec_n, min_n, hr_n, dow_n, date_n, mon_n, yr_n;
   wire       sec_w, min_w, hr_w, dow_w, date_w, mon_w, yr_w;
   wire [6:0] sec_b, min_b, hr_b, dow_b, date_b, mon_b, yr_b;
   wire       leap  = yr_b[1:0] == 2'b00;
   wire [6:0] mdays = (mon_b == 7'd2) ? (leap ? 7'd29 : 7'd28) :
                      (mon_b == 7'd4 || mon_b == 7'd6 || mon_b == 7'd9 || mon_b == 7'd11) ? 7'd30 : 7'd31;

   rtc_field_step u_sec (.val_i(tk_ff[0]), .max_i(7'd59), .min_i(7'd0), .bcd_i(bcd),
                         .nxt_o(sec_n), .wrap_o(sec_w), .bin_o(sec_b));
   rtc_field_step u_min (.val_i(tk_ff[2]), .max_i(7'd59), .min_i(7'd0), .bcd_i(bcd),
                         .nxt_o(min_n), .wrap_o(min_w), .bin_o(min_b));
   rtc_field_step u_hr (.val_i({1'b0, tk_ff[4][6:0]}), .max_i(hr24_ff ? 7'd23 : 7'd12),
                        .min_i(hr24_ff ? 7'd0 : 7'd1), .bcd_i(bcd),
                        .nxt_o(hr_n), .wrap_o(hr_w), .bin_o(hr_b));
   rtc_field_step u_dow (.val_i(tk_ff[6]), .max_i(7'd7), .min_i(7'd1), .bcd_i(bcd),
                         .nxt_o(dow_n), .wrap_o(dow_w), .bin_o(dow_b));
   rtc_field_step u_date (.val_i(tk_ff[7]), .max_i(mdays), .min_i(7'd1), .bcd_i(bcd),
                          .nxt_o(date_n), .wrap_o(date_w), .bin_o(date_b));
   rtc_field_step u_mon (.val_i(tk_ff[8]), .max_i(7'd12), .min_i(7'd1), .bcd_i(bcd),
                         .nxt_o(mon_n), .wrap_o(mon_w), .bin_o(mon_b));
   rtc_field_step u_yr (.val_i(tk_ff[9]), .max_i(7'd99), .min_i(7'd0), .bcd_i(bcd),
                        .nxt_o(yr_n), .wrap_o(yr_w), .bin_o(yr_b));

   // Next time after one update, including hour format and daylight saving
   reg [7:0] nxt_sec, nxt_min, nxt_hr, nxt_dow, nxt_date, nxt_mon, nxt_yr;
   reg       day_carry;
   reg       dst_edge;
   reg       nxt_fall;
   always @* begin
      nxt_sec   = sec_n;                                                       // [R24]
      nxt_min   = tk_ff[2];
      nxt_hr    = tk_ff[4];
      nxt_dow   = tk_ff[6];
      nxt_date  = tk_ff[7];
      nxt_mon   = tk_ff[8];
      nxt_yr    = tk_ff[9];
      nxt_fall  = fall_done_ff;
      day_carry = 1'b0;
      dst_edge  = dse_ff && tk_ff[4] == 8'h01 && sec_b == 7'd59 && min_b == 7'd59 && dow_b == 7'd1;
      if (sec_w) begin
         nxt_min = min_n;
         if (min_w) begin
            if (hr24_ff) begin                                                 // [R20]
               nxt_hr    = hr_n;
               day_carry = hr_w;
            end else if (hr_b == 7'd11) begin
               // 11 to 12 flips AM/PM; 11 PM rolls the day
               nxt_hr    = {~tk_ff[4][7], (bcd ? 7'h12 : 7'h0c)};
               day_carry = tk_ff[4][7];
            end else begin
               nxt_hr = {tk_ff[4][7], hr_n[6:0]};
            end
         end
      end
      if (day_carry) begin
         nxt_dow  = dow_n;
         nxt_date = date_n;
         nxt_fall = 1'b0;
         if (date_w) begin
            nxt_mon = mon_n;
            if (mon_w) begin
               nxt_yr = yr_n;
            end
         end
      end
      if (dst_edge && mon_b == 7'd4 && date_b <= 7'd7) begin                   // [R19]
         nxt_hr  = 8'h03;
         nxt_min = 8'h00;
         nxt_sec = 8'h00;
      end else if (dst_edge && mon_b == 7'd10 && date_b >= 7'd25 && ~fall_done_ff) begin // [R19]
         nxt_hr   = 8'h01;
         nxt_min  = 8'h00;
         nxt_sec  = 8'h00;
         nxt_fall = 1'b1;
      end
   end

   // Alarm compare with don't-care bytes
   function alarm_hit;
      input [7:0] alm;
      input [7:0] tim;
      begin
         alarm_hit = (alm[7:6] == `ALARM_ANY) || (alm == tim);                  // [R4]
      end
   endfunction
   wire alarm_match = alarm_hit(tk_ff[1], tk_ff[0]) && alarm_hit(tk_ff[3], tk_ff[2]) &&
                      alarm_hit(tk_ff[5], tk_ff[4]);

   // Next flags; an event beats the read clear
   wire nxt_pf  = ~pwr_clear & ((pf_ff & ~rd_flags) | per_evt);                 // [R14] [R15] [R26]
   wire nxt_uf  = ~pwr_clear & ((uf_ff & ~rd_flags) | upd_evt);                 // [R14] [R15] [R26]
   wire nxt_af  = ~pwr_clear & ((af_ff & ~rd_flags) | (alarm_chk_ff & alarm_match)); // [R3] [R15]
   wire nxt_pie = ~pwr_clear & (b_wr ? io_wdata_i[`B_PIE_BIT] : pie_ff);
   wire nxt_aie = ~pwr_clear & (b_wr ? io_wdata_i[`B_AIE_BIT] : aie_ff);
   wire nxt_uie = ~pwr_clear & (b_wr ? io_wdata_i[`B_UIE_BIT] : uie_ff);
   wire nxt_irq = (nxt_pf & nxt_pie) | (nxt_af & nxt_aie) | (nxt_uf & nxt_uie); // [R13]

   // Two-stage synchronisers for the async pins
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         sy1_ff      <= 4'h0;
         sy2_ff      <= 4'h0;
         osc_prev_ff <= 1'b0;
         bat_prev_ff <= 1'b0;
      end else begin
         sy1_ff      <= {master_reset_input_i, batt_low_i, on_battery_i, osc_32k_i}; // [R27] [R28]
         sy2_ff      <= sy1_ff;
         osc_prev_ff <= osc_s;
         bat_prev_ff <= bat_s;
      end
   end

   // Power lockout timer and sticky RAM lock
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         inputs_locked_o <= 1'b0;
         lk_cnt_ff       <= 23'h000000;
         lock_ff         <= 1'b0;
      end else begin
         lock_ff <= lock_ff | ram_lock_set_i;                                  // [R7]
         if (bat_s) begin
            inputs_locked_o <= 1'b1;                                           // [R8]
            lk_cnt_ff       <= 23'h000000;
         end else if (bat_fall) begin
            if (pwr_clear || dv_ff != `DV_NORMAL || ~vrt_ff) begin             // [R9] [R10]
               inputs_locked_o <= 1'b0;
            end else begin
               lk_cnt_ff <= LOCKOUT_CYCLES;                                    // [R8]
            end
         end else if (lk_cnt_ff != 23'h000000) begin
            lk_cnt_ff <= lk_cnt_ff - 23'h000001;
            if (lk_cnt_ff == 23'h000001) begin
               inputs_locked_o <= 1'b0;
            end
         end
      end
   end

   // Battery-backed state; reset leaves it
   always @(posedge mclk_i) begin                                              // [R22]
      if (blow_s) begin
         vrt_ff <= 1'b0;
      end else if (rd_valid) begin
         vrt_ff <= 1'b1;
      end
      if (pwr_clear) begin                                                     // [R10]
         for (i = 0; i < 10; i = i + 1) begin
            tk_ff[i] <= 8'h00;
         end
         rs_ff        <= 4'h0;
         dv_ff        <= 3'b000;
         set_ff       <= 1'b0;
         dm_ff        <= 1'b0;
         hr24_ff      <= 1'b0;
         dse_ff       <= 1'b0;
         div_ff       <= 15'h0000;
         fall_done_ff <= 1'b0;
      end else begin
         if (div_hold) begin
            div_ff <= 15'h0000;                                                // [R17]
         end else if (div_step) begin
            div_ff <= div_nxt;
         end
         if (upd_evt) begin
            tk_ff[0]     <= nxt_sec;
            tk_ff[2]     <= nxt_min;
            tk_ff[4]     <= nxt_hr;
            tk_ff[6]     <= nxt_dow;
            tk_ff[7]     <= nxt_date;
            tk_ff[8]     <= nxt_mon;
            tk_ff[9]     <= nxt_yr;
            fall_done_ff <= nxt_fall;
         end
         if (t_wr) begin
            tk_ff[idx_ff[3:0]] <= io_wdata_i;
         end
         if (a_wr) begin
            rs_ff <= io_wdata_i[`A_RS_MSB:`A_RS_LSB];
            dv_ff <= io_wdata_i[`A_DV_MSB:`A_DV_LSB];
         end
         if (b_wr) begin
            set_ff  <= io_wdata_i[`B_SET_BIT];
            dm_ff   <= io_wdata_i[`B_DM_BIT];
            hr24_ff <= io_wdata_i[`B_HR24_BIT];
            dse_ff  <= io_wdata_i[`B_DSE_BIT];
         end
      end
   end

   // General-purpose RAM, oscillator-independent
   always @(posedge mclk_i) begin
      if (dat_wr && ~clk_area && ~lock_cell) begin                             // [R5] [R6] [R12]
         gp_ram_ff[ram_addr] <= io_wdata_i;
      end
   end

   // Read data selection
   always @* begin
      rd_val = 8'h00;
      if (inputs_locked_o) begin
         rd_val = `LOCKED_READ_VAL;
      end else if (io_addr_i == `IDX_PORT_ADDR) begin
         rd_val = {1'b0, idx_ff};
      end else if (~clk_area) begin
         rd_val = lock_cell ? `LOCKED_READ_VAL : gp_ram_ff[ram_addr];          // [R6]
      end else if (idx_ff < `TIME_REG_COUNT) begin
         rd_val = tk_ff[idx_ff[3:0]];
      end else if (idx_ff == `REG_RATE_DIV) begin
         rd_val = {uip_now & ~set_ff, dv_ff, rs_ff};                           // [R18]
      end else if (idx_ff == `REG_MODE_EN) begin
         rd_val = {set_ff, pie_ff, aie_ff, uie_ff, 1'b0, dm_ff, hr24_ff, dse_ff}; // [R21]
      end else if (idx_ff == `REG_IRQ_FLAGS) begin
         rd_val = {~irq_out_n_o, pf_ff, af_ff, uf_ff, 4'h0};
      end else begin
         rd_val = {vrt_ff, 7'h00};
      end
   end

   // Host registers, flags, interrupt pin
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         idx_ff       <= `IDX_RST;
         io_rdata_o   <= `RDATA_RST;
         io_rvalid_o  <= 1'b0;
         pie_ff       <= 1'b0;
         aie_ff       <= 1'b0;
         uie_ff       <= 1'b0;
         pf_ff        <= 1'b0;                                                 // [R26]
         af_ff        <= 1'b0;
         uf_ff        <= 1'b0;
         alarm_chk_ff <= 1'b0;
         irq_out_n_o  <= 1'b1;
         osc_enable_o <= 1'b0;
      end else begin
         if (idx_wr) begin
            idx_ff <= io_wdata_i[6:0];                                          // [R23]
         end
         io_rvalid_o  <= rd_any;
         if (rd_any) begin
            io_rdata_o <= rd_val;
         end
         alarm_chk_ff <= upd_evt;                                              // [R3]
         pf_ff        <= nxt_pf;
         af_ff        <= nxt_af;
         uf_ff        <= nxt_uf;
         pie_ff       <= nxt_pie;
         aie_ff       <= nxt_aie;
         uie_ff       <= nxt_uie;
         irq_out_n_o  <= ~nxt_irq;                                             // [R13] [R14]
         osc_enable_o <= osc_run;                                              // [R11] [R12]
      end
   end

endmodule // rtc_alarm_interrupt_core

//--- core/rtc_core_regs.vh
// Clock core constants: ports, indexes, fields, resets, timing.
// Assumes a 100 MHz core clock and a 32.768 kHz oscillator.
`ifndef RTC_CORE_REGS_VH
`define RTC_CORE_REGS_VH

// Host I/O port addresses
`define IDX_PORT_ADDR      8'h70
`define DATA_PORT_ADDR     8'h71

// Register indexes in the clock area
`define TIME_REG_COUNT     7'h0a
`define REG_RATE_DIV       7'h0a
`define REG_MODE_EN        7'h0b
`define REG_IRQ_FLAGS      7'h0c
`define REG_VALID          7'h0d
`define RAM_BANK0_FIRST    7'h0e
`define LOCK_FIRST         7'h38
`define LOCK_LAST          7'h3f
`define LOCKED_READ_VAL    8'hff

// Field positions, rate_and_divider_control
`define A_DV_MSB           6
`define A_DV_LSB           4
`define A_RS_MSB           3
`define A_RS_LSB           0
// Field positions, mode_and_enable_control
`define B_SET_BIT          7
`define B_PIE_BIT          6
`define B_AIE_BIT          5
`define B_UIE_BIT          4
`define B_DM_BIT           2
`define B_HR24_BIT         1
`define B_DSE_BIT          0

// Codes and reset values
`define DV_NORMAL          3'b010
`define ALARM_ANY          2'b11
`define IDX_RST            7'h00
`define RDATA_RST          8'h00

// Timing
`define OSC_HZ             32768
`define UIP_LEAD_US        244
`define UIP_LEAD_TICKS     ((`UIP_LEAD_US * `OSC_HZ + 999999) / 1000000)
`define DIV_UPDATE_AT      15'h3fff
`define LOCKOUT_MS         62
`define CLK_MHZ            100

`endif

//--- core/rtc_field_step.v
// Steps one time field in BCD or binary.
// Assumes a legal value; min_i below ten.
`timescale 1ns/1ps

module rtc_field_step (
   // Field value and limits
   input  wire [7:0] val_i,
   input  wire [6:0] max_i,
   input  wire [6:0] min_i,
   input  wire       bcd_i,
   // Advanced value, wrap flag and binary view of the input
   output reg  [7:0] nxt_o,
   output reg        wrap_o,
   output reg  [6:0] bin_o
);

   reg [7:0] tens_sum;

   // Binary view, wrap test and increment
   always @* begin
      tens_sum = ({4'h0, val_i[7:4]} * 8'd10) + {4'h0, val_i[3:0]};
      if (bcd_i) begin
         bin_o = tens_sum[6:0];
      end else begin
         bin_o = val_i[6:0];
      end
      wrap_o = (bin_o >= max_i);
      if (wrap_o) begin
         nxt_o = {1'b0, min_i};
      end else if (bcd_i && val_i[3:0] == 4'h9) begin
         nxt_o = {val_i[7:4] + 4'h1, 4'h0};
      end else begin
         nxt_o = val_i + 8'h01;
      end
   end

endmodule // rtc_field_step

//--- verification/rtc_core_sva.sv
// Port checker for the clock core.
// Bound to the core; index and lock rebuilt from traffic.
`timescale 1ns/1ps
module rtc_core_sva (
   // Clock and reset
   input wire       mclk_i,
   input wire       nrst_i,
   // Host port
   input wire [7:0] io_addr_i,
   input wire       io_wr_i,
   input wire       io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire       io_rvalid_o,
   // Configuration and power
   input wire       ram_lock_set_i,
   input wire       on_battery_i,
   input wire       batt_low_i,
   input wire       master_reset_input_i,
   // Status
   input wire       irq_out_n_o,
   input wire       inputs_locked_o
);
   reg  [6:0] idx_ff;
   reg        lock_ff;
   wire       port_rd = io_rd_i && io_addr_i[7:1] == 7'h38;
   wire       data_rd = io_rd_i && io_addr_i == 8'h71 && !inputs_locked_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // Expected index and lock
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         idx_ff  <= 7'h00;
         lock_ff <= 1'b0;
      end else begin
         if (io_wr_i && io_addr_i == 8'h70 && !inputs_locked_o) idx_ff <= io_wdata_i[6:0];
         if (ram_lock_set_i) lock_ff <= 1'b1;
      end
   end
   read_answer_a: assert property (port_rd |=> io_rvalid_o)
      else $error("read strobe not answered");
   answer_cause_a: assert property (io_rvalid_o |-> $past(io_rd_i))
      else $error("read valid without a read");
   reset_values_a: assert property ($rose(nrst_i) |-> irq_out_n_o && !io_rvalid_o && !inputs_locked_o)
      else $error("outputs wrong after reset");
   battery_lock_a: assert property (on_battery_i [*5] |-> inputs_locked_o)
      else $error("host not locked on battery");
   locked_read_a: assert property (port_rd && inputs_locked_o |=> io_rdata_o == 8'hff)
      else $error("locked read not all ones");
   ram_lock_a: assert property (data_rd && lock_ff && idx_ff[6:3] == 4'h7 |=> io_rdata_o == 8'hff)
      else $error("locked ram read not all ones");
   irq_mirror_a: assert property (data_rd && idx_ff == 7'h0c |=>
      io_rdata_o[7] == !$past(irq_out_n_o) && io_rdata_o[3:0] == 4'h0)
      else $error("flag byte does not mirror interrupt");
   mode_bit3_a: assert property (data_rd && idx_ff == 7'h0b |=> !io_rdata_o[3])
      else $error("mode bit 3 not zero");
   lowbat_open_a: assert property ($fell(on_battery_i) && batt_low_i && master_reset_input_i
      |-> ##[1:6] !inputs_locked_o)
      else $error("low battery return kept lock");
endmodule // rtc_core_sva

//--- verification/rtc_host_model.sv
// Host model on the index/data port.
// One call at a time; strobes pulse.
`timescale 1ns/1ps
module rtc_host_model (
   // Clock
   input  wire        mclk_i,
   // Bus towards the core
   output logic [7:0] io_addr_o = 8'h00,
   output logic       io_wr_o = 1'b0,
   output logic       io_rd_o = 1'b0,
   output logic [7:0] io_wdata_o = 8'h00,
   input  wire  [7:0] io_rdata_i,
   input  wire        io_rvalid_i
);
   // Index write always comes before the data access
   task automatic sel(input logic [6:0] idx);
      @(posedge mclk_i);
      io_addr_o  <= 8'h70;
      io_wr_o    <= 1'b1;
      io_wdata_o <= {1'b0, idx};
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      sel(idx);
      @(posedge mclk_i);
      io_addr_o  <= 8'h71;
      io_wdata_o <= d;
      @(posedge mclk_i);
      io_wr_o    <= 1'b0;
      io_addr_o  <= 8'h00;
      io_wdata_o <= ~d; // Released data changes
   endtask
   task automatic rd(input logic [6:0] idx, output logic [7:0] d);
      sel(idx);
      @(posedge mclk_i);
      io_wr_o    <= 1'b0;
      io_rd_o    <= 1'b1;
      io_addr_o  <= 8'h71;
      io_wdata_o <= ~io_wdata_o;
      @(posedge mclk_i);
      io_rd_o    <= 1'b0;
      io_addr_o  <= 8'h00;
      @(posedge mclk_i);
      d = (io_rvalid_i === 1'b1) ? io_rdata_i : 8'hxx;
   endtask
endmodule // rtc_host_model

//--- verification/rtc_alarm_interrupt_core_tb.sv
// Self-checking bench for the clock core.
// Lockout shortened; oscillator ticks every 4 cycles.
`timescale 1ns/1ps
module rtc_alarm_interrupt_core_tb;
   logic       mclk_i = 1'b0, nrst_i = 1'b0, ram_bank_sel_i = 1'b0, ram_lock_set_i = 1'b0;
   logic       on_battery_i = 1'b1, batt_low_i = 1'b1, master_reset_input_i = 1'b1;
   logic [1:0] osc_ph = 2'b00;
   wire        osc_32k_i = osc_ph[1];
   wire  [7:0] io_addr_i, io_wdata_i, io_rdata_o;
   wire        io_wr_i, io_rd_i, io_rvalid_o, irq_out_n_o, osc_enable_o, inputs_locked_o;
   int         err_total = 0, total_checks = 0;
   logic [7:0] d, v;
   logic [6:0] ix;
   realtime    t1, t2;
   logic [3:0] rsl [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h1, 4'h2};
   rtc_alarm_interrupt_core #(.LOCKOUT_CYCLES(23'd50)) uut (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .ram_bank_sel_i(ram_bank_sel_i),
      .ram_lock_set_i(ram_lock_set_i), .osc_32k_i(osc_32k_i), .on_battery_i(on_battery_i),
      .batt_low_i(batt_low_i), .master_reset_input_i(master_reset_input_i),
      .irq_out_n_o(irq_out_n_o), .osc_enable_o(osc_enable_o), .inputs_locked_o(inputs_locked_o));
   rtc_host_model host (.mclk_i(mclk_i), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i),
      .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o), .io_rvalid_i(io_rvalid_o));
   // Clock and oscillator
   initial forever #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) osc_ph <= osc_ph + 2'd1;
   // Comparisons and helpers
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %b, seen %b", n, e, g);
      end
   endtask
   task automatic chk_int(input string n, input int e, input int g);
      total_checks++;
      if (g != e) begin
         err_total++;
         $display("unexpected %s: expected %0d, seen %0d", n, e, g);
      end
   endtask
   task automatic rdc(input logic [6:0] i, input logic [7:0] e, input string n);
      host.rd(i, d);
      chk(n, e, d);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wait_irq(output realtime t);
      int k = 0;
      while (irq_out_n_o !== 1'b0 && k < 5000) begin
         @(posedge mclk_i);
         k++;
      end
      t = $realtime;
   endtask
   // Periodic spacing in core cycles
   function automatic int pf_cycles(input logic [3:0] rs);
      int r;
      r = (rs == 4'h1) ? 8 : (rs == 4'h2) ? 9 : int'(rs);
      return (1 << (r - 1)) * 4;
   endfunction
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog
   initial begin
      waitc(40000);
      err_total++;
      end_sim;
   end
   // Test sequence
   initial begin
      v = 8'($urandom(32'h1837));
      waitc(16);
      nrst_i <= 1'b1;
      waitc(2);
      on_battery_i <= 1'b0;
      waitc(6);
      chk_bit("lock at return", 1'b0, inputs_locked_o);
      batt_low_i <= 1'b0;
      master_reset_input_i <= 1'b0;
      waitc(4);
      for (int i = 0; i < 13; i++) rdc(7'(i), 8'h00, "cleared reg");
      host.wr(7'h0a, 8'h20);
      waitc(4);
      chk_bit("osc before valid", 1'b0, osc_enable_o);
      rdc(7'h0d, 8'h00, "valid first");
      rdc(7'h0d, 8'h80, "valid second");
      chk_bit("osc when valid", 1'b1, osc_enable_o);
      $display("test power return done");
      host.wr(7'h0b, 8'h0f);
      rdc(7'h0b, 8'h07, "mode bit 3");
      repeat (8) begin
         ix = 7'h0e + 7'($urandom % 114);
         v = 8'($urandom);
         host.wr(ix, v);
         rdc(ix, v, "ram bank0");
      end
      ram_bank_sel_i <= 1'b1;
      ix = 7'($urandom % 10);
      v = 8'($urandom) | 8'h01;
      host.wr(ix, v);
      rdc(ix, v, "ram bank1");
      ram_bank_sel_i <= 1'b0;
      rdc(ix, 8'h00, "time under bank0");
      $display("test ram banks done");
      host.wr(7'h3a, 8'h5a);
      ram_lock_set_i <= 1'b1;
      waitc(1);
      ram_lock_set_i <= 1'b0;
      host.wr(7'h3a, 8'h00);
      rdc(7'h3a, 8'hff, "locked ram");
      host.wr(7'h0a, 8'h6f);
      host.wr(7'h0b, 8'h7f);
      rdc(7'h0b, 8'h77, "mode write");
      nrst_i <= 1'b0;
      waitc(3);
      nrst_i <= 1'b1;
      rdc(7'h0b, 8'h07, "mode after reset");
      rdc(7'h0c, 8'h00, "flags after reset");
      host.rd(7'h0a, d);
      chk("rate after reset", 8'h6f, d & 8'h7f);
      rdc(7'h3a, 8'h5a, "ram after unlock");
      $display("test lock and reset done");
      host.wr(7'h0a, 8'h20);
      host.wr(7'h20, 8'h3c);
      on_battery_i <= 1'b1;
      waitc(5);
      chk_bit("lock on battery", 1'b1, inputs_locked_o);
      rdc(7'h20, 8'hff, "locked read");
      host.wr(7'h20, 8'h11);
      on_battery_i <= 1'b0;
      waitc(40);
      chk_bit("lock held", 1'b1, inputs_locked_o);
      waitc(20);
      chk_bit("lock ended", 1'b0, inputs_locked_o);
      rdc(7'h20, 8'h3c, "ram kept");
      host.wr(7'h0a, 8'h06);
      waitc(4);
      chk_bit("osc stopped", 1'b0, osc_enable_o);
      rdc(7'h20, 8'h3c, "ram with osc off");
      on_battery_i <= 1'b1;
      waitc(5);
      on_battery_i <= 1'b0;
      waitc(6);
      chk_bit("no lockout", 1'b0, inputs_locked_o);
      $display("test lockout done");
      host.wr(7'h0b, 8'h40);
      foreach (rsl[i]) begin
         host.wr(7'h0a, {4'h2, rsl[i]});
         host.rd(7'h0c, d);
         wait_irq(t1);
         rdc(7'h0c, 8'hc0, "periodic flags");
         wait_irq(t2);
         chk_int("periodic spacing", pf_cycles(rsl[i]), int'((t2 - t1) / 10.0));
      end
      host.wr(7'h0a, 8'h20);
      host.rd(7'h0c, d);
      waitc(600);
      chk_bit("no periodic", 1'b1, irq_out_n_o);
      $display("test periodic rates done");
      end_sim;
   end
endmodule // rtc_alarm_interrupt_core_tb
bind rtc_alarm_interrupt_core rtc_core_sva chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i),
   .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
   .io_rvalid_o(io_rvalid_o), .ram_lock_set_i(ram_lock_set_i), .on_battery_i(on_battery_i),
   .batt_low_i(batt_low_i), .master_reset_input_i(master_reset_input_i), .irq_out_n_o(irq_out_n_o),
   .inputs_locked_o(inputs_locked_o));
